// >>> hdl/burst_sram_byte_write_mask.sv
// Write-port masking, burst commit and read output staging of a burst SRAM
// Functional notes
// R1: x8 mode: each low nibble mask writes its nibble, high keeps it.
// R2: x18 mode: first lane mask governs bits 8..0; upper half kept.
// R3: x18 mode: second lane mask governs bits 17..9; lower half kept.
// R4: x9 mode: one mask writes all nine bits or nothing.
// R5: x36 mode: four masks each govern one 9-bit lane.
// R6: x36 mode: all masks low writes the whole 36-bit word.
// R7: all masks high on a beat writes nothing; burst still proceeds.
// R8: data and masks captured at K rise and again at inverted K rise.
// R9: each beat uses its own mask values, independently.
// R10: first beat goes to latched address, second to address plus one.
// R11: after reset the port is deselected and outputs are high-impedance.
// R12: read data leaves on output clock rises, or K clocks in single mode.
// R13: controller should park all clocks high while stopped; the bench parks K and K# high but holds C and C# low in dual mode.
// R14: write starts on select low at K rise; address at inverted K rise.
// R15: output clocks high at power-on select single clock mode, fixed.
// R16: one write enable per lane per beat; two words to A and A+1.
`timescale 1ns/1ps
`default_nettype none
module burst_sram_byte_write_mask (
   input  wire logic                                    i_core_clk,
   input  wire logic                                    i_reset,
   input  wire burst_sram_wmask_pkg::width_cfg_type     i_width_cfg,
   input  wire logic                                    i_k,
   input  wire logic                                    i_k_n,
   input  wire logic                                    i_c,
   input  wire logic                                    i_c_n,
   input  wire logic                                    i_write_port_select_n,
   input  wire logic                                    i_read_port_select_n,
   input  wire logic [burst_sram_wmask_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [burst_sram_wmask_pkg::DATA_W-1:0] i_d,
   input  wire logic [burst_sram_wmask_pkg::LANES-1:0]  i_lane_write_mask_n,
   input  wire logic [1:0]                              i_nibble_write_mask_n,
   input  wire burst_sram_wmask_pkg::read_pair_type     i_arr_rdata,
   output var  burst_sram_wmask_pkg::array_write_type   o_arr_wr,
   output logic [burst_sram_wmask_pkg::ADDR_W-1:0]      o_rd_addr,
   output logic                                         o_rd_req,
   output logic [burst_sram_wmask_pkg::DATA_W-1:0]      o_q,
   output logic                                         o_q_oe
);
   import burst_sram_wmask_pkg::*;

   wmask_state_type st_reg;
   wmask_state_type st_next;
   logic            k_rise;
   logic            kn_rise;
   logic            pos_rise;
   logic            neg_rise;
   logic            wr_start;
   logic            rd_start;

   // Per-bit write enables from one beat's masks, by configuration
   function automatic logic [DATA_W-1:0] lane_bits(width_cfg_type cfg, beat_type b);
      logic [DATA_W-1:0] m;
      m = '0;
      case (cfg)
         CFG_X8: begin
            m[NIB0_LSB +: NIBBLE_W] = {NIBBLE_W{~b.nibble_mask_n[0]}}; // [R1]
            m[NIB1_LSB +: NIBBLE_W] = {NIBBLE_W{~b.nibble_mask_n[1]}}; // [R1]
         end
         CFG_X9: begin
            m[LANE0_LSB +: LANE_W] = {LANE_W{~b.lane_mask_n[0]}}; // [R4]
         end
         CFG_X18: begin
            m[LANE0_LSB +: LANE_W] = {LANE_W{~b.lane_mask_n[0]}}; // [R2]
            m[LANE1_LSB +: LANE_W] = {LANE_W{~b.lane_mask_n[1]}}; // [R3]
         end
         CFG_X36: begin
            // All four low gives the full word [R6]
            m[LANE0_LSB +: LANE_W] = {LANE_W{~b.lane_mask_n[0]}}; // [R5]
            m[LANE1_LSB +: LANE_W] = {LANE_W{~b.lane_mask_n[1]}}; // [R5]
            m[LANE2_LSB +: LANE_W] = {LANE_W{~b.lane_mask_n[2]}}; // [R5]
            m[LANE3_LSB +: LANE_W] = {LANE_W{~b.lane_mask_n[3]}}; // [R5]
         end
         default: begin
            m = '0;
         end
      endcase
      return m;
   endfunction : lane_bits

   function automatic array_write_type commit(width_cfg_type cfg, beat_type b,
                                              logic [ADDR_W-1:0] a);
      array_write_type w;
      w.bit_we = lane_bits(cfg, b); // [R16]
      w.we     = |w.bit_we; // [R7]
      w.addr   = a;
      w.data   = b.data;
      return w;
   endfunction : commit

   function automatic beat_type grab(logic [DATA_W-1:0] d, logic [LANES-1:0] l,
                                     logic [1:0] n);
      beat_type b;
      b.data          = d;
      b.lane_mask_n   = l;
      b.nibble_mask_n = n;
      return b;
   endfunction : grab

   always_comb begin
      // Input clocks are sampled levels; rises found against last sample
      k_rise   = i_k & ~st_reg.k_prev;
      kn_rise  = i_k_n & ~st_reg.kn_prev;
      pos_rise = st_reg.single_clk ? k_rise : (i_c & ~st_reg.c_prev); // [R12]
      neg_rise = st_reg.single_clk ? kn_rise : (i_c_n & ~st_reg.cn_prev); // [R12]
      wr_start = k_rise & ~i_write_port_select_n; // [R14]
      rd_start = k_rise & ~i_read_port_select_n;

      st_next         = st_reg;
      st_next.k_prev  = i_k;
      st_next.kn_prev = i_k_n;
      st_next.c_prev  = i_c;
      st_next.cn_prev = i_c_n;
      st_next.arr.we  = 1'b0;
      st_next.rd_req  = 1'b0;

      case (st_reg.wr_state)
         WR_IDLE: begin
            if (wr_start) begin
               st_next.beat0 = grab(i_d, i_lane_write_mask_n, i_nibble_write_mask_n); // [R8]
               st_next.wr_state = WR_WAIT_KN;
            end
         end
         WR_WAIT_KN: begin
            if (kn_rise) begin
               st_next.wr_addr = i_addr; // [R14]
               st_next.beat1 = grab(i_d, i_lane_write_mask_n, i_nibble_write_mask_n); // [R8]
               st_next.wr_state = WR_COMMIT0;
            end
         end
         WR_COMMIT0: begin
            st_next.arr = commit(st_reg.cfg, st_reg.beat0, st_reg.wr_addr); // [R10]
            st_next.wr_state = WR_COMMIT1;
         end
         WR_COMMIT1: begin
            // Second word uses its own masks, not the first beat's [R9]
            st_next.arr = commit(st_reg.cfg, st_reg.beat1,
                                 ADDR_W'(st_reg.wr_addr + BURST_STEP)); // [R10]
            st_next.wr_state = WR_IDLE;
            if (wr_start) begin
               st_next.beat0 = grab(i_d, i_lane_write_mask_n, i_nibble_write_mask_n);
               st_next.wr_state = WR_WAIT_KN;
            end
         end
         default: begin
            st_next.wr_state = WR_IDLE;
         end
      endcase

      if (rd_start) begin
         st_next.rd_addr = i_addr;
         st_next.rd_req  = 1'b1;
      end

      // Read latency is one and a half K cycles to the first word
      case (st_reg.rd_state)
         RD_IDLE: begin
            st_next.q_oe = 1'b0; // [R11]
            if (rd_start) begin
               st_next.rd_state = RD_LAT;
            end
         end
         RD_LAT: begin
            if (neg_rise) begin
               st_next.q_oe = 1'b0;
            end
            if (pos_rise && !rd_start) begin
               st_next.rd_state = RD_WAIT0;
            end
         end
         RD_WAIT0: begin
            if (neg_rise) begin
               st_next.q        = i_arr_rdata.word0; // [R12]
               st_next.rd_word1 = i_arr_rdata.word1;
               st_next.q_oe     = 1'b1;
               st_next.rd_state = RD_WORD1;
            end
         end
         RD_WORD1: begin
            if (pos_rise) begin
               st_next.q        = st_reg.rd_word1; // [R12]
               st_next.rd_state = RD_HOLD;
            end
         end
         RD_HOLD: begin
            // A read start here returns to RD_LAT, which releases the bus at the next neg_rise
            if (rd_start) begin
               st_next.rd_state = RD_LAT;
            end else if (neg_rise) begin
               st_next.q_oe     = 1'b0;
               st_next.rd_state = RD_IDLE;
            end
         end
         default: begin
            st_next.rd_state = RD_IDLE;
         end
      endcase

      if (i_reset) begin
         st_next            = STATE_RESET; // [R11]
         // Straps are caught while reset is held and stay fixed after
         st_next.cfg        = i_width_cfg;
         st_next.single_clk = i_c & i_c_n; // [R15]
         st_next.k_prev     = i_k;
         st_next.kn_prev    = i_k_n;
         st_next.c_prev     = i_c;
         st_next.cn_prev    = i_c_n;
      end
   end

   always_ff @(posedge i_core_clk) begin
      st_reg <= st_next;
   end

   assign o_arr_wr  = st_reg.arr;
   assign o_rd_addr = st_reg.rd_addr;
   assign o_rd_req  = st_reg.rd_req;
   assign o_q       = st_reg.q;
   assign o_q_oe    = st_reg.q_oe;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);

   chk_nibble_lanes: assert property ( // [R1]
      (st_reg.cfg == CFG_X8 && st_reg.wr_state == WR_COMMIT0) |=>
      o_arr_wr.bit_we[7:0] == {{4{~$past(st_reg.beat0.nibble_mask_n[1])}},
                               {4{~$past(st_reg.beat0.nibble_mask_n[0])}}}
      && o_arr_wr.bit_we[35:8] == '0)
      else $error("nibble enables do not follow nibble masks");

   chk_half_lanes: assert property ( // [R2] [R3]
      (st_reg.cfg == CFG_X18 && st_reg.wr_state == WR_COMMIT1) |=>
      o_arr_wr.bit_we[17:0] == {{9{~$past(st_reg.beat1.lane_mask_n[1])}},
                                {9{~$past(st_reg.beat1.lane_mask_n[0])}}}
      && o_arr_wr.bit_we[35:18] == '0)
      else $error("x18 lane enables wrong");

   chk_single_lane: assert property ( // [R4]
      (st_reg.cfg == CFG_X9 && st_reg.wr_state == WR_COMMIT0) |=>
      o_arr_wr.bit_we == {27'h0000000, {9{~$past(st_reg.beat0.lane_mask_n[0])}}})
      else $error("x9 enable wrong");

   chk_quad_lanes: assert property ( // [R5] [R6]
      (st_reg.cfg == CFG_X36 && st_reg.wr_state == WR_COMMIT0) |=>
      o_arr_wr.bit_we == {{9{~$past(st_reg.beat0.lane_mask_n[3])}},
                          {9{~$past(st_reg.beat0.lane_mask_n[2])}},
                          {9{~$past(st_reg.beat0.lane_mask_n[1])}},
                          {9{~$past(st_reg.beat0.lane_mask_n[0])}}})
      else $error("x36 lane enables wrong");

   chk_masked_beat: assert property ( // [R7]
      (st_reg.wr_state == WR_COMMIT0 && st_reg.cfg == CFG_X36 && &st_reg.beat0.lane_mask_n)
      |=> !o_arr_wr.we ##1 (st_reg.wr_state != WR_COMMIT1))
      else $error("fully masked beat wrote or stalled burst");

   chk_beat_capture: assert property ( // [R8] [R9]
      (st_reg.wr_state == WR_WAIT_KN && kn_rise) |=>
      st_reg.beat1.lane_mask_n == $past(i_lane_write_mask_n)
      && st_reg.beat1.data == $past(i_d) && st_reg.wr_addr == $past(i_addr))
      else $error("second beat not captured at inverted K rise");

   chk_burst_addr: assert property ( // [R10] [R16]
      (st_reg.wr_state == WR_COMMIT0) |=>
      o_arr_wr.addr == $past(st_reg.wr_addr)
      ##1 o_arr_wr.addr == ADDR_W'($past(st_reg.wr_addr, 2) + BURST_STEP))
      else $error("burst address order wrong");

   chk_write_start: assert property ( // [R14]
      (st_reg.wr_state == WR_IDLE && wr_start) |=>
      st_reg.wr_state == WR_WAIT_KN && st_reg.beat0.data == $past(i_d))
      else $error("write start not taken at K rise");

   chk_idle_float: assert property ( // [R11]
      (st_reg.rd_state == RD_IDLE) |=> !o_q_oe || $past(st_reg.rd_state) != RD_IDLE)
      else $error("read bus driven while idle");

   chk_read_edge: assert property ( // [R12]
      (st_reg.rd_state == RD_WAIT0 && neg_rise) |=>
      o_q_oe && o_q == $past(i_arr_rdata.word0))
      else $error("first read word not driven at output clock");

   chk_second_word: assert property ( // [R12]
      (st_reg.rd_state == RD_WORD1 && pos_rise) |=>
      o_q_oe && o_q == $past(st_reg.rd_word1))
      else $error("second read word not driven at output clock");

   chk_bus_release: assert property ( // [R11] [R12]
      (st_reg.rd_state == RD_HOLD && neg_rise && !rd_start) |=> !o_q_oe)
      else $error("read bus not released after second word");

   // A third write pulse in a row would mean a beat was committed twice
   chk_two_words: assert property ( // [R16]
      o_arr_wr.we |=> !o_arr_wr.we || $past(st_reg.wr_state) == WR_COMMIT1)
      else $error("array write pulse longer than one burst");

   cov_x36_partial: cover property (
      st_reg.cfg == CFG_X36 && o_arr_wr.we && !(&o_arr_wr.bit_we));
   cov_back_to_back: cover property (
      st_reg.wr_state == WR_COMMIT1 && wr_start);
   cov_read_burst: cover property (
      st_reg.rd_state == RD_WORD1 && pos_rise);
   cov_single_clk: cover property (st_reg.single_clk && o_q_oe);

endmodule : burst_sram_byte_write_mask
`default_nettype wire

// >>> hdl/burst_sram_wmask_pkg.sv
// Shared types and constants for the burst SRAM write-mask block
package burst_sram_wmask_pkg;

   localparam int DATA_W    = 36;
   localparam int ADDR_W    = 23;
   localparam int LANES     = 4;
   localparam int NIBBLES   = 2;
   localparam int LANE_W    = 9;
   localparam int NIBBLE_W  = 4;
   localparam int LANE0_LSB = 0;
   localparam int LANE1_LSB = 9;
   localparam int LANE2_LSB = 18;
   localparam int LANE3_LSB = 27;
   localparam int NIB0_LSB  = 0;
   localparam int NIB1_LSB  = 4;
   localparam logic [ADDR_W-1:0] BURST_STEP = 23'h000001;

   typedef enum logic [1:0] {CFG_X8, CFG_X9, CFG_X18, CFG_X36} width_cfg_type;
   typedef enum logic [1:0] {WR_IDLE, WR_WAIT_KN, WR_COMMIT0, WR_COMMIT1} wr_state_type;
   typedef enum logic [2:0] {RD_IDLE, RD_LAT, RD_WAIT0, RD_WORD1, RD_HOLD} rd_state_type;

   typedef struct packed {
      logic [DATA_W-1:0]  data;
      logic [LANES-1:0]   lane_mask_n;
      logic [NIBBLES-1:0] nibble_mask_n;
   } beat_type;

   typedef struct packed {
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] bit_we;
      logic [DATA_W-1:0] data;
   } array_write_type;

   typedef struct packed {
      logic [DATA_W-1:0] word0;
      logic [DATA_W-1:0] word1;
   } read_pair_type;

   typedef struct packed {
      wr_state_type      wr_state;
      rd_state_type      rd_state;
      width_cfg_type     cfg;
      logic              single_clk;
      logic              k_prev;
      logic              kn_prev;
      logic              c_prev;
      logic              cn_prev;
      beat_type          beat0;
      beat_type          beat1;
      logic [ADDR_W-1:0] wr_addr;
      array_write_type   arr;
      logic [ADDR_W-1:0] rd_addr;
      logic              rd_req;
      logic [DATA_W-1:0] q;
      logic              q_oe;
      logic [DATA_W-1:0] rd_word1;
   } wmask_state_type;

   localparam wmask_state_type STATE_RESET = '0;

endpackage : burst_sram_wmask_pkg

// >>> sim/tb.sv
// Self-checking bench for the burst SRAM write-mask block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import burst_sram_wmask_pkg::*;
   logic                   i_core_clk = 1'b0;
   logic                   i_reset = 1'b1;
   width_cfg_type          cfg = CFG_X8;
   wire logic              k;
   wire logic              k_n;
   wire logic              wps_n;
   wire logic [ADDR_W-1:0] addr;
   wire logic [DATA_W-1:0] d;
   wire logic [LANES-1:0]  lane_n;
   wire logic [1:0]        nib_n;
   wire logic              rps_n;
   wire logic              c_pin;
   wire logic              c_n_pin;
   logic                   single = 1'b0;
   read_pair_type          rdata = '0;
   logic [DATA_W-1:0]      q;
   logic [ADDR_W-1:0]      rd_addr;
   logic [DATA_W-1:0]      exp_rd[$];
   logic [DATA_W-1:0]      last_q = '0;
   logic                   last_oe = 1'b0;
   array_write_type        arr_wr;
   array_write_type        e;
   logic                   rd_req;
   logic                   q_oe;
   array_write_type        exp_q[$];
   int                     fails = 0;
   int                     cmp_count = 0;
   initial forever #2.5 i_core_clk = ~i_core_clk;
   // Dual mode: output clocks follow K but stay low in reset so the strap reads dual
   assign c_pin   = single | (k & !i_reset);
   assign c_n_pin = single | (k_n & !i_reset);
   burst_sram_byte_write_mask u_dut (
      .i_core_clk            (i_core_clk),
      .i_reset               (i_reset),
      .i_width_cfg           (cfg),
      .i_k                   (k),
      .i_k_n                 (k_n),
      .i_c                   (c_pin), // Both high in reset only when single is set: single clock mode
      .i_c_n                 (c_n_pin),
      .i_write_port_select_n (wps_n),
      .i_read_port_select_n  (rps_n),
      .i_addr                (addr),
      .i_d                   (d),
      .i_lane_write_mask_n   (lane_n),
      .i_nibble_write_mask_n (nib_n),
      .i_arr_rdata           (rdata),
      .o_arr_wr              (arr_wr),
      .o_rd_addr             (rd_addr),
      .o_rd_req              (rd_req),
      .o_q                   (q),
      .o_q_oe                (q_oe)
   );
   wport_ctl_model u_ctl (
      .i_core_clk (i_core_clk),
      .i_park     (i_reset),
      .o_k        (k),
      .o_k_n      (k_n),
      .o_wps_n    (wps_n),
      .o_rps_n    (rps_n),
      .o_addr     (addr),
      .o_d        (d),
      .o_lane_n   (lane_n),
      .o_nib_n    (nib_n)
   );
   function automatic logic [DATA_W-1:0] lane_bits(input width_cfg_type c, input beat_type b);
      logic [DATA_W-1:0] w;
      w = '0;
      case (c)
         CFG_X8: w[7:0] = {{4{~b.nibble_mask_n[1]}}, {4{~b.nibble_mask_n[0]}}};
         CFG_X9: w[8:0] = {9{~b.lane_mask_n[0]}};
         CFG_X18: w[17:0] = {{9{~b.lane_mask_n[1]}}, {9{~b.lane_mask_n[0]}}};
         default: for (int i = 0; i < LANES; i++) begin
            w[i*LANE_W +: LANE_W] = {LANE_W{~b.lane_mask_n[i]}};
         end
      endcase
      return w;
   endfunction : lane_bits
   function automatic beat_type rand_beat();
      beat_type b;
      b.data = DATA_W'({$urandom(), $urandom()});
      b.lane_mask_n = LANES'($urandom());
      b.nibble_mask_n = NIBBLES'($urandom());
      return b;
   endfunction : rand_beat
   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at time %0t: got %h expected %h", $realtime, got, exp);
      end
   endtask : check
   // Expectations are queued before the burst is driven
   task automatic burst(input logic [ADDR_W-1:0] a, input beat_type b0, input beat_type b1);
      array_write_type x;
      x.we = 1'b1;
      x.addr = a;
      x.bit_we = lane_bits(cfg, b0);
      x.data = b0.data & x.bit_we;
      if (x.bit_we != '0) exp_q.push_back(x); // Fully masked beat writes nothing
      x.addr = a + BURST_STEP;
      x.bit_we = lane_bits(cfg, b1);
      x.data = b1.data & x.bit_we;
      if (x.bit_we != '0) exp_q.push_back(x);
      u_ctl.write_burst(a, b0, b1);
   endtask : burst
   always @(posedge i_core_clk) begin
      if (!i_reset && arr_wr.we === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(DATA_W'(arr_wr.we), '0); // No write was due
         end else begin
            e = exp_q.pop_front();
            check(arr_wr.bit_we, e.bit_we);
            check(DATA_W'(arr_wr.addr), DATA_W'(e.addr));
            check(arr_wr.data & arr_wr.bit_we, e.data);
         end
      end
   end
   // Read side: address on the request pulse, then each new word on the bus
   always @(posedge i_core_clk) begin
      if (!i_reset && rd_req === 1'b1) begin
         if (exp_rd.size() == 0) begin
            check(DATA_W'(rd_req), '0);
         end else begin
            check(DATA_W'(rd_addr), exp_rd.pop_front());
         end
      end
      if (!i_reset && q_oe === 1'b1 && (last_oe !== 1'b1 || q !== last_q)) begin
         if (exp_rd.size() == 0) begin
            check(DATA_W'(q_oe), '0);
         end else begin
            check(q, exp_rd.pop_front());
         end
      end
      last_q  <= q;
      last_oe <= q_oe;
   end
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (40000) @(posedge i_core_clk);
      fails++;
      give_verdict();
   end
   initial begin
      beat_type b0;
      beat_type b1;
      logic [ADDR_W-1:0] ra;
      logic [DATA_W-1:0] w0;
      void'($urandom(32'h707e));
      for (int c = 0; c < 4; c++) begin
         @(posedge i_core_clk);
         i_reset <= 1'b1;
         cfg     <= width_cfg_type'(c[1:0]);
         single  <= c[0];
         repeat (10) @(posedge i_core_clk);
         i_reset <= 1'b0;
         @(posedge i_core_clk);
         #1;
         check(DATA_W'(q_oe), '0); // Deselected, outputs off
         check(DATA_W'(rd_req), '0);
         b0 = rand_beat();
         b0.lane_mask_n = '0;
         b0.nibble_mask_n = '0;
         b1 = rand_beat();
         b1.lane_mask_n = '1;
         b1.nibble_mask_n = '1;
         burst(ADDR_W'($urandom()), b0, b1);
         burst(23'h7fffff, b1, b0); // Address wraps on second beat
         for (int n = 0; n < 12; n++) begin
            burst(ADDR_W'($urandom()), rand_beat(), rand_beat());
         end
         for (int w = 0; w < 40 && exp_q.size() != 0; w++) @(posedge i_core_clk);
         check(DATA_W'(exp_q.size()), '0); // All queued words committed
         exp_q.delete();
         // Words differ so the monitor sees the second one arrive
         w0 = DATA_W'({$urandom(), $urandom()});
         ra = ADDR_W'($urandom());
         rdata <= '{word0: w0, word1: ~w0};
         exp_rd.push_back(DATA_W'(ra));
         exp_rd.push_back(w0);
         exp_rd.push_back(~w0);
         u_ctl.read_burst(ra);
         for (int w = 0; w < 40 && exp_rd.size() != 0; w++) begin
            @(posedge i_core_clk);
         end
         repeat (8) @(posedge i_core_clk);
         check(DATA_W'(exp_rd.size()), '0); // Both read words delivered
         check(DATA_W'(q_oe), '0); // Bus released after second word
         exp_rd.delete();
         $display("test width config %0d done", c);
      end
      give_verdict();
   end
endmodule : tb
`default_nettype wire

// >>> sim/wport_ctl_model.sv
// Behavioural write-port controller for the burst SRAM write-mask block
`timescale 1ns/1ps
`default_nettype none
module wport_ctl_model (
   input  wire logic                                    i_core_clk,
   input  wire logic                                    i_park,
   output logic                                         o_k,
   output logic                                         o_k_n,
   output logic                                         o_wps_n,
   output logic                                         o_rps_n,
   output logic [burst_sram_wmask_pkg::ADDR_W-1:0]      o_addr,
   output logic [burst_sram_wmask_pkg::DATA_W-1:0]      o_d,
   output logic [burst_sram_wmask_pkg::LANES-1:0]       o_lane_n,
   output logic [burst_sram_wmask_pkg::NIBBLES-1:0]     o_nib_n
);
   import burst_sram_wmask_pkg::*;
   logic [2:0] ph = 3'h3;
   initial begin
      o_k = 1'b1;
      o_k_n = 1'b1;
      o_wps_n = 1'b1;
      o_rps_n = 1'b1;
      o_addr = '0;
      o_d = '0;
      o_lane_n = '1;
      o_nib_n = '1;
   end
   // Eight core cycles per K period keeps like edges four cycles apart
   always @(posedge i_core_clk) begin
      if (i_park) begin
         o_k   <= 1'b1; // Both parked high for a quick restart
         o_k_n <= 1'b1;
         ph    <= 3'h3;
      end else begin
         ph <= ph + 3'h1;
         if (ph == 3'h3) begin
            o_k   <= 1'b0;
            o_k_n <= 1'b1; // Second beat edge
         end
         if (ph == 3'h7) begin
            o_k   <= 1'b1; // First beat edge
            o_k_n <= 1'b0;
         end
      end
   end
   // Bounded: a stalled phase leaves expectations unmet, which counts
   task automatic wait_ph(input logic [2:0] p);
      for (int i = 0; i < 16; i++) begin
         @(posedge i_core_clk);
         if (ph == p) begin
            break;
         end
      end
   endtask : wait_ph
   task automatic read_burst(input logic [ADDR_W-1:0] a);
      wait_ph(3'h7);
      o_rps_n <= 1'b0; // Select and address held up to the K rise
      o_addr  <= a;
      wait_ph(3'h0);
      o_rps_n <= 1'b1;
      o_addr  <= ~a;
   endtask : read_burst
   task automatic write_burst(input logic [ADDR_W-1:0] a, input beat_type b0, input beat_type b1);
      wait_ph(3'h7);
      o_wps_n  <= 1'b0; // Select low at K rise
      o_d      <= b0.data;
      o_lane_n <= b0.lane_mask_n;
      o_nib_n  <= b0.nibble_mask_n;
      wait_ph(3'h3);
      o_wps_n  <= 1'b1;
      o_addr   <= a; // Address at inverted K rise
      o_d      <= b1.data;
      o_lane_n <= b1.lane_mask_n; // Each beat carries its own masks
      o_nib_n  <= b1.nibble_mask_n;
      wait_ph(3'h4);
      // Released lines flip so a stale value cannot pass
      o_addr   <= ~a;
      o_d      <= ~b1.data;
      o_lane_n <= ~b1.lane_mask_n;
      o_nib_n  <= ~b1.nibble_mask_n;
   endtask : write_burst
endmodule : wport_ctl_model
`default_nettype wire
